// >>> inc/ir_remote_pkg.sv
// Constants shared by the infrared remote transceiver design
package ir_remote_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_CONTROL = 10'h0b0;
	localparam logic [9:0] IDX_STATUS = 10'h0b1;
	localparam logic [9:0] IDX_RX_COUNT = 10'h0b2;
	localparam logic [9:0] IDX_TX_COUNT = 10'h0b3;
	localparam logic [9:0] IDX_RX_FIFO = 10'h0b4;
	localparam logic [9:0] IDX_TX_FIFO = 10'h0b5;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// Control fields
	localparam int CTL_START_BIT = 0;
	localparam int CTL_FMT_BIT = 1;
	localparam int CTL_RXIE_BIT = 2;
	localparam int CTL_TXIE_BIT = 3;
	localparam logic [7:0] CTL_MASK = 8'h0f;
	localparam logic [7:0] CTL_RESET = 8'h00;
	// Status fields
	localparam int ST_OVF_BIT = 0;
	localparam int ST_RXDONE_BIT = 2;
	localparam int ST_TXDONE_BIT = 3;
	localparam logic [7:0] ST_RESET = 8'h00;
	localparam logic [7:0] EMPTY_READ = 8'hff;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// Buffer sizes
	localparam int FIFO_DEPTH = 255;
	localparam int LEN_DEPTH = 16;
	// Timing: one modulation unit per format, in ns
	localparam int CLK_PERIOD_NS = 10;
	localparam int UNIT0_NS = 500000;
	localparam int UNIT1_NS = 400000;
	localparam int UNIT0_CYC = UNIT0_NS / CLK_PERIOD_NS;
	localparam int UNIT1_CYC = UNIT1_NS / CLK_PERIOD_NS;
	// Frame shape in units
	localparam int LEAD_MARK0 = 16;
	localparam int LEAD_SPACE0 = 8;
	localparam int LEAD_MARK1 = 8;
	localparam int LEAD_SPACE1 = 4;
	localparam int BIT_UNITS = 1;
	localparam int ONE_SPACE_UNITS = 3;
	localparam int ONE_THRESH_UNITS = 2;
	localparam int GAP_UNITS = 16;
	localparam int END_UNITS = 5;
	localparam int CNT_W = 24;
	// Read path kinds
	localparam logic [1:0] RD_NONE = 2'h0;
	localparam logic [1:0] RD_LEN = 2'h1;
	localparam logic [1:0] RD_DATA = 2'h2;
endpackage

// >>> rtl/ir_byte_fifo.sv
// Byte FIFO with occupancy count
`timescale 1ns/1ps
`default_nettype none
module ir_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 255,
	parameter int LW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] head,
	output logic full,
	output logic empty,
	output logic [LW-1:0] level
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [PW-1:0] PZERO = '0;
	localparam logic [LW-1:0] LFULL = LW'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [LW-1:0] level_r;
	logic do_push;
	logic do_pop;

	// Pushes into a full FIFO are dropped; only the receive caller flags them
	assign full = (level_r == LFULL);
	assign empty = (level_r == '0);
	assign do_push = push & ~full;
	assign do_pop = pop & ~empty;
	assign head = mem[rd_ptr_r];
	assign level = level_r;

	always_ff @(posedge pclk) begin
		if (do_push) begin
			mem[wr_ptr_r] <= push_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			level_r <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_r <= (wr_ptr_r == LAST) ? PZERO : wr_ptr_r + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_r <= (rd_ptr_r == LAST) ? PZERO : rd_ptr_r + 1'b1;
			end
			if (do_push && !do_pop) begin
				level_r <= level_r + 1'b1;
			end else if (do_pop && !do_push) begin
				level_r <= level_r - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/ir_remote_top.sv
// Infrared remote transceiver with APB registers and byte FIFOs
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ir_remote_top import ir_remote_pkg::*; #(
	parameter int UNIT0_CYCLES = UNIT0_CYC,
	parameter int UNIT1_CYCLES = UNIT1_CYC,
	parameter int RX_DEPTH = FIFO_DEPTH,
	parameter int TX_DEPTH = FIFO_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ir_rx_in,
	output logic ir_tx_out,
	output logic irq
);
	typedef enum logic [2:0] {
		TX_IDLE, TX_LEAD_M, TX_LEAD_S, TX_BIT_M, TX_BIT_S, TX_STOP, TX_GAP
	} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_LEAD_S, RX_DATA} rx_state_t;

	logic [7:0] ctl_r;
	logic [7:0] st_r;
	logic [7:0] prdata_r;
	logic [1:0] rd_kind_r;
	logic irq_r;
	logic enable;
	logic fmt;
	logic access;
	logic setup;
	logic [9:0] idx;
	logic hit_ctl, hit_st, hit_rxc, hit_txc, hit_rxf, hit_txf;
	logic mapped;
	logic wr;
	logic rd;
	logic [CNT_W-1:0] unit_cyc;

	// FIFO wiring
	logic rxd_push, rxd_pop, rxd_full, rxd_empty;
	logic [7:0] rxd_data, rxd_head, rxd_level;
	logic rxl_push, rxl_pop, rxl_full, rxl_empty;
	logic [7:0] rxl_head, rxl_level;
	logic txd_push, txd_pop, txd_full, txd_empty;
	logic [7:0] txd_head, txd_level;
	logic txl_push, txl_pop, txl_full, txl_empty;
	logic [7:0] txl_head, txl_level;
	logic [7:0] rx_left_r;
	logic [7:0] tx_left_r;

	// Transmit engine
	tx_state_t tx_state_r;
	logic [CNT_W-1:0] tx_cnt_r;
	logic [7:0] tx_bytes_r;
	logic [7:0] tx_shift_r;
	logic [2:0] tx_bit_r;
	logic tx_out_r;
	logic tx_load;
	logic tx_done;

	// Receive decoder
	rx_state_t rx_state_r;
	logic [CNT_W-1:0] rx_cnt_r;
	logic rx_prev_r;
	logic [7:0] rx_shift_r;
	logic [2:0] rx_bit_r;
	logic [7:0] rx_bytes_r;
	logic rx_fall;
	logic rx_rise;
	logic rx_bit_val;
	logic rx_byte_done;
	logic rx_end;
	logic rx_done;
	logic rx_ovf;

	function automatic logic [CNT_W-1:0] cyc_of(input logic [CNT_W-1:0] u, input int n);
		cyc_of = CNT_W'(u * n);
	endfunction

	function automatic logic in_window(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] nom);
		// Accept within a quarter of nominal either way
		in_window = (c >= nom - (nom >> 2)) && (c <= nom + (nom >> 2));
	endfunction

	assign enable = ctl_r[CTL_START_BIT];
	assign fmt = ctl_r[CTL_FMT_BIT];
	assign unit_cyc = fmt ? CNT_W'(UNIT1_CYCLES) : CNT_W'(UNIT0_CYCLES);

	// APB decode; every access completes with no wait state
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign idx = paddr[ADDR_W-1:2];
	assign hit_ctl = (idx == IDX_CONTROL);
	assign hit_st = (idx == IDX_STATUS);
	assign hit_rxc = (idx == IDX_RX_COUNT);
	assign hit_txc = (idx == IDX_TX_COUNT);
	assign hit_rxf = (idx == IDX_RX_FIFO);
	assign hit_txf = (idx == IDX_TX_FIFO);
	assign mapped = (hit_ctl | hit_st | hit_rxc | hit_txc | hit_rxf | hit_txf) &
		(paddr[1:0] == 2'b00);
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign wr = access & pwrite & mapped;
	assign rd = access & ~pwrite & mapped;
	assign prdata = {24'h00_0000, prdata_r};
	assign irq = irq_r;
	assign ir_tx_out = tx_out_r;

	// Read data is captured in the setup cycle so it stands through the access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= ZERO_BYTE;
			rd_kind_r <= RD_NONE;
		end else if (setup && !pwrite) begin
			rd_kind_r <= RD_NONE;
			prdata_r <= ZERO_BYTE;
			if (hit_ctl) begin
				prdata_r <= ctl_r;
			end else if (hit_st) begin
				prdata_r <= st_r;
			end else if (hit_rxc) begin
				prdata_r <= rxd_level;
			end else if (hit_txc) begin
				prdata_r <= txd_level;
			end else if (hit_rxf) begin
				if (rx_left_r == ZERO_BYTE) begin
					// Each frame reads out as its byte count, then its bytes
					prdata_r <= rxl_empty ? EMPTY_READ : rxl_head;
					rd_kind_r <= rxl_empty ? RD_NONE : RD_LEN;
				end else begin
					prdata_r <= rxd_empty ? EMPTY_READ : rxd_head;
					rd_kind_r <= rxd_empty ? RD_NONE : RD_DATA;
				end
			end
		end
	end

	assign rxl_pop = rd & hit_rxf & (rd_kind_r == RD_LEN);
	assign rxd_pop = rd & hit_rxf & (rd_kind_r == RD_DATA);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_left_r <= ZERO_BYTE;
		end else if (rxl_pop) begin
			rx_left_r <= rxl_head;
		end else if (rxd_pop) begin
			rx_left_r <= rx_left_r - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r <= CTL_RESET;
		end else if (wr && hit_ctl) begin
			ctl_r <= pwdata[7:0] & CTL_MASK;
		end
	end

	// Flags clear on a written zero; a set in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_RESET;
		end else begin
			st_r[ST_OVF_BIT] <= rx_ovf |
				(st_r[ST_OVF_BIT] & ~(wr & hit_st & ~pwdata[ST_OVF_BIT]));
			st_r[ST_RXDONE_BIT] <= rx_done |
				(st_r[ST_RXDONE_BIT] & ~(wr & hit_st & ~pwdata[ST_RXDONE_BIT]));
			st_r[ST_TXDONE_BIT] <= tx_done |
				(st_r[ST_TXDONE_BIT] & ~(wr & hit_st & ~pwdata[ST_TXDONE_BIT]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (st_r[ST_RXDONE_BIT] & ctl_r[CTL_RXIE_BIT]) |
				(st_r[ST_TXDONE_BIT] & ctl_r[CTL_TXIE_BIT]);
		end
	end

	// Transmit writes: first byte of a frame is its count, kept apart from data
	assign txl_push = wr & hit_txf & (tx_left_r == ZERO_BYTE);
	assign txd_push = wr & hit_txf & (tx_left_r != ZERO_BYTE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_left_r <= ZERO_BYTE;
		end else if (txl_push && !txl_full) begin
			tx_left_r <= pwdata[7:0];
		end else if (txd_push) begin
			tx_left_r <= tx_left_r - 1'b1;
		end
	end

	// A frame starts only once all of its bytes are queued
	assign txl_pop = (tx_state_r == TX_IDLE) & enable & ~txl_empty &
		(txd_level >= txl_head);
	// Gated by start so a stop at a byte boundary cannot pop an unsent byte
	assign tx_load = enable & (tx_cnt_r == '0) & (tx_bytes_r != ZERO_BYTE) &
		((tx_state_r == TX_LEAD_S) | ((tx_state_r == TX_BIT_S) & (tx_bit_r == 3'd7)));
	assign txd_pop = tx_load;
	assign tx_done = (tx_state_r == TX_GAP) & (tx_cnt_r == '0) & enable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state_r <= TX_IDLE;
			tx_cnt_r <= '0;
			tx_bytes_r <= ZERO_BYTE;
			tx_shift_r <= ZERO_BYTE;
			tx_bit_r <= 3'd0;
			tx_out_r <= 1'b0;
		end else if (!enable) begin
			tx_state_r <= TX_IDLE;
			tx_out_r <= 1'b0;
			tx_cnt_r <= '0;
		end else if (tx_state_r == TX_IDLE) begin
			if (txl_pop) begin
				tx_bytes_r <= txl_head;
				tx_state_r <= TX_LEAD_M;
				tx_out_r <= 1'b1;
				tx_cnt_r <= cyc_of(unit_cyc, fmt ? LEAD_MARK1 : LEAD_MARK0) - 1'b1;
			end
		end else if (tx_cnt_r != '0) begin
			tx_cnt_r <= tx_cnt_r - 1'b1;
		end else begin
			case (tx_state_r)
				TX_LEAD_M: begin
					tx_state_r <= TX_LEAD_S;
					tx_out_r <= 1'b0;
					tx_cnt_r <= cyc_of(unit_cyc, fmt ? LEAD_SPACE1 : LEAD_SPACE0) - 1'b1;
				end
				TX_BIT_M: begin
					tx_state_r <= TX_BIT_S;
					tx_out_r <= 1'b0;
					tx_cnt_r <= cyc_of(unit_cyc, tx_shift_r[0] ? ONE_SPACE_UNITS : BIT_UNITS) -
						1'b1;
				end
				TX_LEAD_S, TX_BIT_S: begin
					tx_out_r <= 1'b1;
					tx_cnt_r <= cyc_of(unit_cyc, BIT_UNITS) - 1'b1;
					if (tx_state_r == TX_BIT_S && tx_bit_r != 3'd7) begin
						tx_shift_r <= {1'b0, tx_shift_r[7:1]};
						tx_bit_r <= tx_bit_r + 1'b1;
						tx_state_r <= TX_BIT_M;
					end else if (tx_load) begin
						tx_shift_r <= txd_head;
						tx_bytes_r <= tx_bytes_r - 1'b1;
						tx_bit_r <= 3'd0;
						tx_state_r <= TX_BIT_M;
					end else begin
						tx_state_r <= TX_STOP;
					end
				end
				TX_STOP: begin
					tx_state_r <= TX_GAP;
					tx_out_r <= 1'b0;
					tx_cnt_r <= cyc_of(unit_cyc, GAP_UNITS) - 1'b1;
				end
				TX_GAP: begin
					tx_state_r <= TX_IDLE;
				end
				default: begin
					tx_state_r <= TX_IDLE;
					tx_out_r <= 1'b0;
				end
			endcase
		end
	end

	// Receive: pulse-distance decode, mark is a high detector level
	assign rx_fall = rx_prev_r & ~ir_rx_in;
	assign rx_rise = ~rx_prev_r & ir_rx_in;
	assign rx_bit_val = (rx_cnt_r > cyc_of(unit_cyc, ONE_THRESH_UNITS));
	assign rx_byte_done = (rx_state_r == RX_DATA) & rx_rise & (rx_bit_r == 3'd7);
	assign rx_end = (rx_state_r == RX_DATA) & ~ir_rx_in &
		(rx_cnt_r >= cyc_of(unit_cyc, END_UNITS));
	assign rxd_data = {rx_bit_val, rx_shift_r[7:1]};
	assign rxd_push = rx_byte_done;
	assign rxl_push = rx_end & (rx_bytes_r != ZERO_BYTE);
	// A byte or count that finds no room is dropped and flagged
	assign rx_ovf = (rxd_push & rxd_full) | (rxl_push & rxl_full);
	assign rx_done = rxl_push & ~rxl_full;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_prev_r <= 1'b0;
			rx_cnt_r <= '0;
		end else begin
			rx_prev_r <= ir_rx_in;
			if (rx_fall || rx_rise) begin
				rx_cnt_r <= '0;
			end else if (rx_cnt_r != '1) begin
				rx_cnt_r <= rx_cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state_r <= RX_IDLE;
			rx_shift_r <= ZERO_BYTE;
			rx_bit_r <= 3'd0;
			rx_bytes_r <= ZERO_BYTE;
		end else if (!enable) begin
			rx_state_r <= RX_IDLE;
		end else begin
			case (rx_state_r)
				RX_IDLE: begin
					// Leader of the other format falls outside the window
					if (rx_fall && in_window(rx_cnt_r,
						cyc_of(unit_cyc, fmt ? LEAD_MARK1 : LEAD_MARK0))) begin
						rx_state_r <= RX_LEAD_S;
					end
				end
				RX_LEAD_S: begin
					if (rx_rise) begin
						if (in_window(rx_cnt_r,
							cyc_of(unit_cyc, fmt ? LEAD_SPACE1 : LEAD_SPACE0))) begin
							rx_state_r <= RX_DATA;
							rx_bit_r <= 3'd0;
							rx_bytes_r <= ZERO_BYTE;
						end else begin
							rx_state_r <= RX_IDLE;
						end
					end else if (rx_cnt_r >= cyc_of(unit_cyc, GAP_UNITS)) begin
						rx_state_r <= RX_IDLE;
					end
				end
				RX_DATA: begin
					if (rx_end) begin
						rx_state_r <= RX_IDLE;
					end else if (rx_rise) begin
						rx_shift_r <= rxd_data;
						rx_bit_r <= rx_bit_r + 1'b1;
						if (rx_byte_done && !rxd_full) begin
							rx_bytes_r <= rx_bytes_r + 1'b1;
						end
					end
				end
				default: begin
					rx_state_r <= RX_IDLE;
				end
			endcase
		end
	end

	ir_byte_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH), .LW(8)) u_rx_data (
		.pclk(pclk), .presetn(presetn), .push(rxd_push), .push_data(rxd_data),
		.pop(rxd_pop), .head(rxd_head), .full(rxd_full), .empty(rxd_empty),
		.level(rxd_level)
	);

	ir_byte_fifo #(.WIDTH(8), .DEPTH(LEN_DEPTH), .LW(8)) u_rx_len (
		.pclk(pclk), .presetn(presetn), .push(rxl_push), .push_data(rx_bytes_r),
		.pop(rxl_pop), .head(rxl_head), .full(rxl_full), .empty(rxl_empty),
		.level(rxl_level)
	);

	ir_byte_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH), .LW(8)) u_tx_data (
		.pclk(pclk), .presetn(presetn), .push(txd_push), .push_data(pwdata[7:0]),
		.pop(txd_pop), .head(txd_head), .full(txd_full), .empty(txd_empty),
		.level(txd_level)
	);

	ir_byte_fifo #(.WIDTH(8), .DEPTH(LEN_DEPTH), .LW(8)) u_tx_len (
		.pclk(pclk), .presetn(presetn), .push(txl_push), .push_data(pwdata[7:0]),
		.pop(txl_pop), .head(txl_head), .full(txl_full), .empty(txl_empty),
		.level(txl_level)
	);
endmodule
`default_nettype wire

// >>> sim/infrared_remote_transceiver_bench.sv
// Self-checking bench for the infrared remote transceiver
`timescale 1ns/1ps
`default_nettype none
module infrared_remote_transceiver_bench import ir_remote_pkg::*;;
	localparam int U0 = 20;
	localparam int U1 = 16;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic ir_rx_in;
	logic ir_tx_out;
	logic irq;
	logic [7:0] rd;
	logic err;
	int fail_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	ir_remote_top #(.UNIT0_CYCLES(U0), .UNIT1_CYCLES(U1), .RX_DEPTH(8), .TX_DEPTH(8)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ir_rx_in(ir_rx_in), .ir_tx_out(ir_tx_out), .irq(irq));
	ir_far_end #(.U_TX(U1)) far_u (.pclk(pclk), .ir_tx_out(ir_tx_out), .ir_rx_in(ir_rx_in));
	initial begin
		forever #5 pclk = ~pclk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// Waits for the slave however long; only the bench timeout ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_check(input string what, input logic [9:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		check(what, {24'h0, rd}, {24'h0, exp});
	endtask
	task automatic t_reset();
		for (int i = 0; i < 4; i++) begin
			rd_check("reset value", IDX_CONTROL + 10'(i), 8'h00);
		end
		check("irq at reset", {31'h0, irq}, 32'h0);
	endtask
	task automatic t_access();
		apb(1'b1, IDX_CONTROL, 8'hf0);
		rd_check("control upper bits", IDX_CONTROL, 8'h00);
		apb(1'b1, IDX_RX_COUNT, 8'h55);
		rd_check("rx count write", IDX_RX_COUNT, 8'h00);
		apb(1'b1, IDX_STATUS, 8'hff);
		rd_check("status write one", IDX_STATUS, 8'h00);
		rd_check("tx fifo read", IDX_TX_FIFO, 8'h00);
		apb(1'b0, IDX_TX_FIFO + 10'h1, 8'h00);
		check("unmapped error", {31'h0, err}, 32'h1);
	endtask
	task automatic t_rx();
		apb(1'b1, IDX_CONTROL, 8'h05);
		far_u.send(U0, LEAD_MARK0, LEAD_SPACE0, 2, 8'h3c);
		repeat (3) @(posedge pclk);
		check("rx irq", {31'h0, irq}, 32'h1);
		rd_check("rx done flag", IDX_STATUS, 8'h04);
		rd_check("rx count", IDX_RX_COUNT, 8'h02);
		rd_check("rx length", IDX_RX_FIFO, 8'h02);
		rd_check("rx byte 0", IDX_RX_FIFO, 8'h3c);
		rd_check("rx byte 1", IDX_RX_FIFO, 8'h3d);
		rd_check("rx empty read", IDX_RX_FIFO, EMPTY_READ);
		apb(1'b1, IDX_STATUS, 8'hfb);
		rd_check("rx flag cleared", IDX_STATUS, 8'h00);
		repeat (3) @(posedge pclk);
		check("irq after clear", {31'h0, irq}, 32'h0);
	endtask
	task automatic t_reject();
		far_u.send(U1, LEAD_MARK1, LEAD_SPACE1, 1, 8'h11);
		repeat (3) @(posedge pclk);
		rd_check("other format flag", IDX_STATUS, 8'h00);
		rd_check("other format count", IDX_RX_COUNT, 8'h00);
		apb(1'b1, IDX_CONTROL, 8'h06);
		apb(1'b1, IDX_CONTROL, 8'h07);
		far_u.send(U1, LEAD_MARK1, LEAD_SPACE1, 1, 8'h11);
		repeat (3) @(posedge pclk);
		rd_check("second format flag", IDX_STATUS, 8'h04);
		rd_check("second format length", IDX_RX_FIFO, 8'h01);
		rd_check("second format byte", IDX_RX_FIFO, 8'h11);
		apb(1'b1, IDX_STATUS, 8'h00);
		apb(1'b1, IDX_CONTROL, 8'h00);
	endtask
	task automatic t_overflow();
		apb(1'b1, IDX_CONTROL, 8'h01);
		far_u.send(U0, LEAD_MARK0, LEAD_SPACE0, 9, 8'h30);
		repeat (3) @(posedge pclk);
		rd_check("overflow flags", IDX_STATUS, 8'h05);
		rd_check("count at full", IDX_RX_COUNT, 8'h08);
		check("masked irq", {31'h0, irq}, 32'h0);
		apb(1'b1, IDX_STATUS, 8'h00);
		rd_check("flags cleared", IDX_STATUS, 8'h00);
	endtask
	task automatic t_tx();
		apb(1'b1, IDX_CONTROL, 8'h0a);
		apb(1'b1, IDX_CONTROL, 8'h0b);
		apb(1'b1, IDX_TX_FIFO, 8'h01);
		apb(1'b1, IDX_TX_FIFO, 8'ha5);
		while (irq !== 1'b1) begin
			@(posedge pclk);
		end
		check("tx byte", {24'h0, far_u.got}, 32'h0000_00a5);
		check("tx bits", far_u.nbits, 32'h0000_0008);
		check("tx leader", far_u.lead_len / U1, LEAD_MARK1);
		check("tx irq", {31'h0, irq}, 32'h1);
		rd_check("tx done flag", IDX_STATUS, 8'h08);
		rd_check("tx count", IDX_TX_COUNT, 8'h00);
		apb(1'b1, IDX_STATUS, 8'hf7);
		repeat (3) @(posedge pclk);
		check("tx irq cleared", {31'h0, irq}, 32'h0);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_access();
		t_rx();
		t_reject();
		t_overflow();
		t_tx();
		stop_test();
	end
endmodule
`default_nettype wire

// >>> sim/ir_far_end.sv
// Emitter and detector model: sends frames, decodes emitted frames
`timescale 1ns/1ps
`default_nettype none
module ir_far_end import ir_remote_pkg::*; #(
	parameter int U_TX = 16
) (
	input wire logic pclk,
	input wire logic ir_tx_out,
	output logic ir_rx_in
);
	int mark_c = 0;
	int space_c = 0;
	int lead_len = 0;
	int nbits = 0;
	logic prev = 1'b0;
	logic was_bit = 1'b0;
	logic [7:0] got = 8'h00;
	// Idle detector line reads no mark
	initial begin
		ir_rx_in = 1'b0;
	end
	task automatic hold(input logic v, input int n);
		ir_rx_in <= v;
		repeat (n) @(posedge pclk);
	endtask
	task automatic send(input int u, input int lm, input int ls, input int n, input logic [7:0] base);
		logic [7:0] b;
		@(posedge pclk);
		hold(1'b1, lm * u);
		hold(1'b0, ls * u);
		for (int i = 0; i < n; i++) begin
			b = base + 8'(i);
			for (int k = 0; k < 8; k++) begin
				hold(1'b1, u);
				hold(1'b0, b[k] ? ONE_SPACE_UNITS * u : u);
			end
		end
		hold(1'b1, u);
		hold(1'b0, (END_UNITS + 2) * u);
	endtask
	// Decoder assumes one frame at a time, at the unit of U_TX
	always @(posedge pclk) begin
		prev <= ir_tx_out;
		if (ir_tx_out) begin
			mark_c <= mark_c + 1;
			if (!prev) begin
				if (was_bit) begin
					got <= {space_c > ONE_THRESH_UNITS * U_TX, got[7:1]};
					nbits <= nbits + 1;
				end
				space_c <= 0;
			end
		end else begin
			space_c <= space_c + 1;
			if (prev) begin
				if (mark_c > 4 * U_TX) begin
					lead_len <= mark_c;
					nbits <= 0;
					was_bit <= 1'b0;
				end else begin
					was_bit <= 1'b1;
				end
				mark_c <= 0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/ir_remote_checker_assertions.sv
// Port checker for the infrared remote transceiver
`timescale 1ns/1ps
`default_nettype none
module ir_remote_checker import ir_remote_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ir_rx_in,
	input wire logic ir_tx_out,
	input wire logic irq
);
	logic [3:0] ctl_s;
	logic acc;
	logic mapped;
	assign acc = psel && penable;
	assign mapped = paddr[1:0] == 2'h0 && paddr[11:2] >= IDX_CONTROL && paddr[11:2] <= IDX_TX_FIFO;
	// Shadow of the control bits, since only the ports are visible
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_s <= 4'h0;
		end else if (acc && pwrite && paddr == {IDX_CONTROL, 2'h0}) begin
			ctl_s <= pwdata[3:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rd(logic [9:0] idx);
		acc && !pwrite && paddr == {idx, 2'h0};
	endsequence
	// Three cycles leave room for the registered output stage
	sequence s_stopped;
		!ctl_s[0] [*3];
	endsequence
	sequence s_masked;
		!(ctl_s[2] || ctl_s[3]) [*3];
	endsequence
	a_zero_wait: assert property (acc |-> pready) else $error("pready low in access");
	a_unmapped_err: assert property (acc && !mapped |-> pslverr) else $error("no error");
	a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("bad error");
	a_ctl_readback: assert property (s_rd(IDX_CONTROL) |-> prdata == {28'h0, ctl_s})
		else $error("control readback differs");
	a_txfifo_wo: assert property (s_rd(IDX_TX_FIFO) |-> prdata == 32'h0)
		else $error("write-only register read nonzero");
	a_status_resv: assert property (s_rd(IDX_STATUS) |-> prdata[31:4] == 28'h0 && !prdata[1])
		else $error("status reserved bits set");
	a_tx_stopped: assert property (s_stopped |-> !ir_tx_out)
		else $error("emitter active while stopped");
	a_irq_masked: assert property (s_masked |-> !irq)
		else $error("interrupt with enables off");
	a_irq_cause: assert property ($rose(irq) |-> $past(ctl_s[2] || ctl_s[3]))
		else $error("interrupt rose without enable");
endmodule
bind ir_remote_top ir_remote_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ir_rx_in(ir_rx_in), .ir_tx_out(ir_tx_out), .irq(irq));
`default_nettype wire
